/* File: design/ddfc_pkg.sv */
// constants for the dual die flash host sequencer
package ddfc_pkg;
  // -------------------------------------------------------------------
  // address geometry
  // -------------------------------------------------------------------
  localparam int ADDR_W       = 27;
  localparam int DATA_W       = 16;
  localparam int SECTOR_BITS  = 16;
  localparam int SECTOR_COUNT = 2048;
  localparam int DIE_BIT      = 26;
  localparam logic [26:0] DIE1_BASE = 27'h4000000;
  // -------------------------------------------------------------------
  // command cycles
  // -------------------------------------------------------------------
  localparam logic [26:0] UNLOCK1_ADDR = 27'h0000555;
  localparam logic [26:0] UNLOCK2_ADDR = 27'h00002aa;
  localparam logic [15:0] UNLOCK1_DATA = 16'h00aa;
  localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [15:0] ERASE_SETUP  = 16'h0080;
  localparam logic [15:0] ERASE_SECTOR = 16'h0030;
  localparam logic [15:0] ID_ENTER     = 16'h0090;
  localparam logic [15:0] ID_EXIT      = 16'h00f0;
  // -------------------------------------------------------------------
  // identification offsets
  // -------------------------------------------------------------------
  localparam logic [26:0] ID_MFR   = 27'h0000000;
  localparam logic [26:0] ID_DEV1  = 27'h0000001;
  localparam logic [26:0] ID_PROT  = 27'h0000002;
  localparam logic [26:0] ID_SECV  = 27'h0000003;
  localparam logic [26:0] ID_DEV2  = 27'h000000e;
  localparam logic [26:0] ID_DEV3  = 27'h000000f;
  // -------------------------------------------------------------------
  // bus timing
  // -------------------------------------------------------------------
  localparam int CLK_NS    = 10;
  localparam int ACC_NS    = 110;
  localparam int WE_NS     = 40;
  localparam int ACC_CYC   = (ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_CYC    = (WE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W     = 8;
  // -------------------------------------------------------------------
  // operations and sequencer states
  // -------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ  = 3'h0,
    OP_ERASE = 3'h1,
    OP_IDRD  = 3'h2
  } ddfc_op_e;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_SETUP = 6'b000010,
    ST_WRLO  = 6'b000100,
    ST_RDLO  = 6'b001000,
    ST_GAP   = 6'b010000,
    ST_BUSY  = 6'b100000
  } ddfc_state_e;
endpackage

/* File: design/ddfc_host.sv */
// host controller for a two-die parallel flash behind one chip select
`timescale 1ns/1ps
module ddfc_host (
  input  wire logic                 clock,
  input  wire logic                 reset_n,
  // user request
  input  wire logic                 reqValid,
  input  wire logic [2:0]           reqOp,
  input  wire logic [26:0]          reqAddr,
  input  wire logic [26:0]          reqIdOffset,
  output logic                      reqReady,
  output logic                      rspValid,
  output logic [15:0]               rspData,
  // flash pins
  output logic [26:0]               flashAddr,
  output logic [15:0]               flashDqOut,
  output logic                      flashDqOe,
  input  wire logic [15:0]          flashDqIn,
  output logic                      flashCe_n,
  output logic                      flashOe_n,
  output logic                      flashWe_n,
  input  wire logic                 readyBusyNOut
);
  // -------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------
  logic [15:0] dqS1_q, dqS2_q;
  logic        rbS1_q, rbS2_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dqS1_q <= 16'h0000;
      dqS2_q <= 16'h0000;
      rbS1_q <= 1'b1;
      rbS2_q <= 1'b1;
    end else begin
      dqS1_q <= flashDqIn;
      dqS2_q <= dqS1_q;
      rbS1_q <= readyBusyNOut;
      rbS2_q <= rbS1_q;
    end
  end

  // -------------------------------------------------------------------
  // cycle script
  // -------------------------------------------------------------------
  // one entry per bus cycle; the die base rides on every address so
  // unlock and argument cycles reach only the addressed die
  function automatic logic [26:0] cmdAddr(input logic [2:0] op,
                                          input logic [2:0] idx,
                                          input logic [26:0] a,
                                          input logic [26:0] off);
    logic [26:0] base;
    logic [26:0] sect;
    base = a & ddfc_pkg::DIE1_BASE;
    sect = {a[26:16], 16'h0000};
    cmdAddr = base;
    if (op == ddfc_pkg::OP_READ) begin
      cmdAddr = a;
    end else if (idx == 3'd0 || (op == ddfc_pkg::OP_ERASE &&
                 (idx == 3'd2 || idx == 3'd3))) begin
      cmdAddr = base | ddfc_pkg::UNLOCK1_ADDR;
    end else if (idx == 3'd1 || idx == 3'd4) begin
      cmdAddr = base | ddfc_pkg::UNLOCK2_ADDR;
    end else if (op == ddfc_pkg::OP_ERASE) begin
      cmdAddr = sect;
    end else if (idx == 3'd2) begin
      // entry carries the sector whose lock state is wanted later
      cmdAddr = sect | ddfc_pkg::UNLOCK1_ADDR;
    end else if (off == ddfc_pkg::ID_PROT) begin
      cmdAddr = sect | off;
    end else begin
      cmdAddr = base | off;
    end
  endfunction

  function automatic logic [15:0] cmdData(input logic [2:0] op,
                                          input logic [2:0] idx);
    cmdData = ddfc_pkg::ID_EXIT;
    if (idx == 3'd0 || idx == 3'd3) cmdData = ddfc_pkg::UNLOCK1_DATA;
    else if (idx == 3'd1 || idx == 3'd4) cmdData = ddfc_pkg::UNLOCK2_DATA;
    else if (op == ddfc_pkg::OP_ERASE && idx == 3'd2)
      cmdData = ddfc_pkg::ERASE_SETUP;
    else if (op == ddfc_pkg::OP_ERASE) cmdData = ddfc_pkg::ERASE_SECTOR;
    else if (idx == 3'd2) cmdData = ddfc_pkg::ID_ENTER;
  endfunction

  // erase: u1 u2 80 u1 u2 30 id: u1 u2 90 read; exit after read.
  // a broken sequence is never issued, so never needs recovery here
  // -------------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------------
  ddfc_pkg::ddfc_state_e state_q, state_d;
  logic [2:0]  op_q, op_d;
  logic [2:0]  idx_q, idx_d;
  logic [7:0]  cnt_q, cnt_d;
  logic [26:0] addr_q, addr_d, off_q, off_d;
  logic [26:0] fa_q, fa_d;
  logic [15:0] fd_q, fd_d, rd_q, rd_d;
  logic        oe_q, oe_d, ce_q, ce_d, rdn_q, rdn_d, wen_q, wen_d;
  logic        rv_q, rv_d, rdy_q, rdy_d, ex_q, ex_d;
  logic        isRead;

  always_comb begin
    state_d = state_q;
    op_d = op_q;
    idx_d = idx_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    off_d = off_q;
    fa_d = fa_q;
    fd_d = fd_q;
    rd_d = rd_q;
    oe_d = oe_q;
    ce_d = ce_q;
    rdn_d = rdn_q;
    wen_d = wen_q;
    rv_d = 1'b0;
    rdy_d = rdy_q;
    ex_d = ex_q;
    isRead = (op_q == ddfc_pkg::OP_READ) ||
             (op_q == ddfc_pkg::OP_IDRD && idx_q == 3'd3 && !ex_q);
    case (state_q)
      ddfc_pkg::ST_IDLE: begin
        if (reqValid && rdy_q) begin
          op_d = reqOp;
          addr_d = reqAddr;
          off_d = reqIdOffset;
          idx_d = 3'd0;
          ex_d = 1'b0;
          rdy_d = 1'b0;
          state_d = ddfc_pkg::ST_SETUP;
        end
      end
      ddfc_pkg::ST_SETUP: begin
        fa_d = cmdAddr(op_q, idx_q, addr_q, off_q);
        fd_d = ex_q ? ddfc_pkg::ID_EXIT : cmdData(op_q, idx_q);
        if (ex_q) fa_d = addr_q & ddfc_pkg::DIE1_BASE;
        ce_d = 1'b0;
        cnt_d = 8'h00;
        if (isRead) begin
          rdn_d = 1'b0;
          state_d = ddfc_pkg::ST_RDLO;
        end else begin
          oe_d = 1'b1;
          wen_d = 1'b0;
          state_d = ddfc_pkg::ST_WRLO;
        end
      end
      ddfc_pkg::ST_WRLO: begin
        cnt_d = cnt_q + 8'h01;
        if (cnt_q == 8'(ddfc_pkg::WE_CYC - 1)) begin
          wen_d = 1'b1;
          state_d = ddfc_pkg::ST_GAP;
        end
      end
      ddfc_pkg::ST_RDLO: begin
        cnt_d = cnt_q + 8'h01;
        // two extra cycles cover the input synchroniser delay
        if (cnt_q == 8'(ddfc_pkg::ACC_CYC + 1)) begin
          rd_d = dqS2_q;
          rdn_d = 1'b1;
          state_d = ddfc_pkg::ST_GAP;
        end
      end
      ddfc_pkg::ST_GAP: begin
        // chip select rises between cycles; needed for the lock readout
        ce_d = 1'b1;
        oe_d = 1'b0;
        state_d = ddfc_pkg::ST_SETUP;
        if (op_q == ddfc_pkg::OP_READ) begin
          rv_d = 1'b1;
          rdy_d = 1'b1;
          state_d = ddfc_pkg::ST_IDLE;
        end else if (op_q == ddfc_pkg::OP_ERASE) begin
          idx_d = idx_q + 3'd1;
          if (idx_q == 3'd5) begin
            cnt_d = 8'h00;
            state_d = ddfc_pkg::ST_BUSY;
          end
        end else if (ex_q) begin
          rv_d = 1'b1;
          rdy_d = 1'b1;
          state_d = ddfc_pkg::ST_IDLE;
        end else if (idx_q == 3'd3) begin
          ex_d = 1'b1;
        end else begin
          idx_d = idx_q + 3'd1;
        end
      end
      ddfc_pkg::ST_BUSY: begin
        // wait more than 8 cycles for busy to reach rbS2_q before trusting the ready level
        if (cnt_q != 8'hff) cnt_d = cnt_q + 8'h01;
        if (cnt_q > 8'h08 && rbS2_q) begin
          rv_d = 1'b1;
          rdy_d = 1'b1;
          state_d = ddfc_pkg::ST_IDLE;
        end
      end
      default: state_d = ddfc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ddfc_pkg::ST_IDLE;
      op_q <= 3'h0;
      idx_q <= 3'h0;
      cnt_q <= 8'h00;
      addr_q <= 27'h0000000;
      off_q <= 27'h0000000;
      fa_q <= 27'h0000000;
      fd_q <= 16'h0000;
      rd_q <= 16'h0000;
      oe_q <= 1'b0;
      ce_q <= 1'b1;
      rdn_q <= 1'b1;
      wen_q <= 1'b1;
      rv_q <= 1'b0;
      rdy_q <= 1'b1;
      ex_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      idx_q <= idx_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      off_q <= off_d;
      fa_q <= fa_d;
      fd_q <= fd_d;
      rd_q <= rd_d;
      oe_q <= oe_d;
      ce_q <= ce_d;
      rdn_q <= rdn_d;
      wen_q <= wen_d;
      rv_q <= rv_d;
      rdy_q <= rdy_d;
      ex_q <= ex_d;
    end
  end

  assign reqReady   = rdy_q;
  assign rspValid   = rv_q;
  assign rspData    = rd_q;
  assign flashAddr  = fa_q;
  assign flashDqOut = fd_q;
  assign flashDqOe  = oe_q;
  assign flashCe_n  = ce_q;
  assign flashOe_n  = rdn_q;
  assign flashWe_n  = wen_q;
endmodule

/* File: tb/ddfc_host_assertions.sv */
// pin sequencing checker for the two-die flash host
`timescale 1ns/1ps
module ddfc_host_assertions (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic [26:0] flashAddr,
  input wire logic [15:0] flashDqOut,
  input wire logic        flashDqOe,
  input wire logic        flashCe_n,
  input wire logic        flashOe_n,
  input wire logic        flashWe_n
);
  // -------------------------------------------------------------------
  // die of the previous write, frozen between write pulses
  // -------------------------------------------------------------------
  logic lastDie_q;
  logic lastDie_d;
  always_comb lastDie_d = flashWe_n ? lastDie_q : flashAddr[26];
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) lastDie_q <= 1'b0;
    else lastDie_q <= lastDie_d;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_we_frame: assert property (!flashWe_n |->
    !flashCe_n && flashDqOe && flashOe_n) else $error("write strobe unframed");
  a_we_width: assert property ($fell(flashWe_n) |->
    !flashWe_n[*4] ##1 flashWe_n) else $error("write pulse not 4 cycles");
  a_unlock_first: assert property ($fell(flashWe_n) &&
    flashDqOut == 16'h00aa |-> flashAddr[25:0] == 26'h555)
    else $error("aa written off 555");
  a_unlock_second: assert property ($fell(flashWe_n) &&
    flashDqOut == 16'h0055 |-> flashAddr[25:0] == 26'h2aa)
    else $error("55 written off 2aa");
  a_erase_sector: assert property ($fell(flashWe_n) &&
    flashDqOut == 16'h0030 |-> flashAddr[15:0] == 16'h0000)
    else $error("erase go not at sector start");
  a_die_kept: assert property ($fell(flashWe_n) &&
    flashDqOut != 16'h00aa |-> flashAddr[26] == lastDie_q)
    else $error("die bit changed inside a sequence");
  a_read_quiet: assert property (!flashOe_n |->
    !flashCe_n && !flashDqOe && flashWe_n) else $error("read overlaps drive");
  a_write_hold: assert property (!flashWe_n && $past(flashWe_n) == 1'b0 |->
    $stable(flashAddr) && $stable(flashDqOut)) else $error("write args moved");
  a_setup_addr: assert property ($fell(flashWe_n) &&
    flashDqOut == 16'h0080 |-> flashAddr[25:0] == 26'h555)
    else $error("erase setup written off 555");
endmodule
bind ddfc_host ddfc_host_assertions u_ddfc_host_assertions (
  .clock(clock), .reset_n(reset_n), .flashAddr(flashAddr),
  .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashCe_n(flashCe_n),
  .flashOe_n(flashOe_n), .flashWe_n(flashWe_n));

/* File: tb/ddfc_flash_model.sv */
// behavioural two-die flash facing the host
`timescale 1ns/1ps
module ddfc_flash_model #(
  parameter int          BUSY_NS = 2000,
  parameter logic [15:0] MFR_ID  = 16'h00c1, // arbitrary value
  parameter logic [15:0] DEV_ID  = 16'h5a10  // arbitrary value
) (
  input wire logic [26:0] flashAddr,
  input wire logic [15:0] flashDqOut,
  input wire logic        flashCe_n,
  input wire logic        flashOe_n,
  input wire logic        flashWe_n,
  output logic [15:0]     flashDqIn,
  output logic            readyBusyNOut
);
  logic [2:0]  step [2] = '{3'h0, 3'h0};
  logic        idMode [2] = '{1'b0, 1'b0};
  logic [10:0] idSec [2] = '{11'h0, 11'h0};
  logic [10:0] erased = 11'h7ff; // one erased sector only, keeps model small
  logic [15:0] last = 16'h0;
  logic        busy = 1'b0;
  assign readyBusyNOut = ~busy;
  always @(posedge busy) #(BUSY_NS) busy = 1'b0;
  function automatic logic [15:0] rd(input logic [26:0] a);
    if (!idMode[a[26]])
      return (a[26:16] == erased) ? 16'hffff : a[15:0] ^ {5'h0, a[26:16]};
    case (a[7:0])
      8'h00: return MFR_ID;
      8'h01: return DEV_ID;
      8'h0e: return DEV_ID + 16'h1;
      8'h0f: return DEV_ID + 16'h2;
      8'h03: return 16'h003f;
      8'h02: return (a[26:16] == idSec[a[26]]) ?
        {15'h0, a[26:16] == 11'h400} : ~last;
      default: return ~last;
    endcase
  endfunction
  function automatic logic ok(input logic [2:0] s, input logic [25:0] a,
                              input logic [15:0] v);
    case (s)
      3'h0, 3'h3: return a == 26'h555 && v == 16'h00aa;
      3'h1, 3'h4: return a == 26'h2aa && v == 16'h0055;
      3'h2: return a == 26'h555 && v == 16'h0080;
      default: return 1'b0;
    endcase
  endfunction
  // released bus shows the inverse of the last word, never a held value
  always_comb flashDqIn = (!flashCe_n && !flashOe_n) ? rd(flashAddr) : ~last;
  always @(posedge flashOe_n) last = rd(flashAddr);
  always @(posedge flashWe_n) begin
    for (int d = 0; d < 2; d++) begin
      if (!flashCe_n && flashAddr[26] == d[0]) begin
        if (idMode[d]) begin
          idMode[d] = (flashDqOut != 16'h00f0);
        end else if (step[d] == 3'h2 && flashDqOut == 16'h0090) begin
          idMode[d] = 1'b1;
          idSec[d] = flashAddr[26:16];
          step[d] = 3'h0;
        end else if (step[d] == 3'h5 && flashDqOut == 16'h0030) begin
          erased = flashAddr[26:16];
          busy = 1'b1;
          step[d] = 3'h0;
        end else begin
          step[d] = ok(step[d], flashAddr[25:0], flashDqOut) ?
            step[d] + 3'h1 : 3'h0;
        end
      end
    end
  end
endmodule

/* File: tb/ddfc_host_tb.sv */
// self-checking bench for the two-die flash host
`timescale 1ns/1ps
module ddfc_host_tb;
  localparam logic [15:0] MFR = 16'h00c1; // arbitrary value
  localparam logic [15:0] DEV = 16'h5a10; // arbitrary value
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        reqValid = 1'b0;
  logic [2:0]  reqOp = 3'h0;
  logic [26:0] reqAddr = 27'h0;
  logic [26:0] reqIdOffset = 27'h0;
  logic        reqReady, rspValid, flashDqOe, readyBusyNOut;
  logic        flashCe_n, flashOe_n, flashWe_n;
  logic [15:0] rspData, flashDqOut, flashDqIn;
  logic [26:0] flashAddr;
  int          fails = 0;
  int          n_compared = 0;
  int          waited;
  always #5 clock = ~clock;
  ddfc_host u_ddfc_host (.clock(clock), .reset_n(reset_n),
    .reqValid(reqValid), .reqOp(reqOp), .reqAddr(reqAddr),
    .reqIdOffset(reqIdOffset), .reqReady(reqReady), .rspValid(rspValid),
    .rspData(rspData), .flashAddr(flashAddr), .flashDqOut(flashDqOut),
    .flashDqOe(flashDqOe), .flashDqIn(flashDqIn), .flashCe_n(flashCe_n),
    .flashOe_n(flashOe_n), .flashWe_n(flashWe_n),
    .readyBusyNOut(readyBusyNOut));
  ddfc_flash_model #(.BUSY_NS(2000), .MFR_ID(MFR), .DEV_ID(DEV))
    u_ddfc_flash_model (.flashAddr(flashAddr), .flashDqOut(flashDqOut),
    .flashCe_n(flashCe_n), .flashOe_n(flashOe_n), .flashWe_n(flashWe_n),
    .flashDqIn(flashDqIn), .readyBusyNOut(readyBusyNOut));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (fails == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [15:0] pat(input logic [26:0] a);
    return a[15:0] ^ {5'h0, a[26:16]};
  endfunction
  // next request starts in the pulse cycle, so every run is back to back
  task automatic run(input logic [2:0] op, input logic [26:0] a,
                     input logic [26:0] off);
    check({15'h0, reqReady}, 16'h0001);
    reqValid = 1'b1;
    reqOp = op;
    reqAddr = a;
    reqIdOffset = off;
    @(posedge clock);
    #1;
    reqValid = 1'b0;
    check({15'h0, reqReady}, 16'h0000);
    waited = 0;
    while (rspValid !== 1'b1 && waited < 5000) begin
      @(posedge clock);
      #1;
      waited++;
    end
    check({15'h0, rspValid}, 16'h0001);
  endtask
  task automatic t_ident();
    logic [26:0] offs [5] = '{27'h0, 27'h1, 27'he, 27'hf, 27'h3};
    logic [15:0] exps [5] = '{MFR, DEV, DEV + 16'h1, DEV + 16'h2, 16'h003f};
    for (int d = 0; d < 2; d++) begin
      for (int i = 0; i < 5; i++) begin
        run(3'h2, {d[0], 26'h0}, offs[i]);
        check(rspData, exps[i]);
      end
    end
  endtask
  task automatic t_prot();
    run(3'h2, 27'h4000000, 27'h2);
    check(rspData, 16'h0001);
    run(3'h2, 27'h0000000, 27'h2);
    check(rspData, 16'h0000);
  endtask
  task automatic t_array();
    run(3'h0, 27'h0012345, 27'h0);
    check(rspData, pat(27'h0012345));
    run(3'h0, 27'h4abcdef, 27'h0);
    check(rspData, pat(27'h4abcdef));
    run(3'h0, 27'h7ffffff, 27'h0);
    check(rspData, 16'hffff);
  endtask
  task automatic t_erase();
    run(3'h1, 27'h4050000, 27'h0);
    check({15'h0, waited >= 200}, 16'h0001);
    run(3'h0, 27'h405abcd, 27'h0);
    check(rspData, 16'hffff);
    run(3'h0, 27'h005abcd, 27'h0);
    check(rspData, pat(27'h005abcd));
  endtask
  initial begin
    #500000;
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge clock);
    #1;
    reset_n = 1'b1;
    t_ident();
    t_prot();
    t_array();
    t_erase();
    report_and_stop();
  end
endmodule
